// ===== tb/host_model.sv
// bus host model driving the link side of the checker
`timescale 1ns/1ps
module host_model (
  output logic lclk,
  output logic sda_h,
  output logic start_det,
  output logic start_rep,
  output logic bus_stop,
  input wire logic sda_w
);
  logic [7:0] crc_q;
  initial begin
    lclk = 1'h0;
    sda_h = 1'h1;
    {start_det, start_rep, bus_stop} = '0;
    crc_q = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) r = r[7] ? {r[6:0], 1'h0} ^ 8'h07 : {r[6:0], 1'h0};
    return r;
  endfunction : crc8
  // scl only runs inside frames; released sda reads high through the pull-up
  task automatic bit_out(input logic b, output logic s);
    sda_h = b;
    #31.25 lclk = 1'h1;
    s = sda_w;
    #62.5 lclk = 1'h0;
    #31.25;
  endtask : bit_out
  task automatic frame(input logic rep, input logic [7:0] a, output logic ack);
    logic s;
    bus_stop = 1'h0;
    #200;
    if (!rep) crc_q = 8'h00;
    start_det = 1'h1;
    start_rep = rep;
    bit_out(1'h1, s);
    start_det = 1'h0;
    for (int i = 7; i >= 0; i--) bit_out(a[i], s);
    bit_out(1'h1, s);
    ack = !s;
    if (!rep) crc_q = crc8(crc_q, a);
  endtask : frame
  // t bit is odd parity unless a scenario asks for a broken one
  task automatic send_byte(input logic [7:0] d, input logic bad);
    logic s;
    for (int i = 7; i >= 0; i--) bit_out(d[i], s);
    bit_out(~^d ^ bad, s);
    crc_q = crc8(crc_q, d);
  endtask : send_byte
  task automatic send_pec(input logic bad);
    send_byte(crc_q ^ {7'h00, bad}, 1'h0);
  endtask : send_pec
  task automatic stop;
    sda_h = 1'h1;
    bus_stop = 1'h1;
  endtask : stop
endmodule : host_model

// ===== tb/tb.sv
// self-checking bench for the pec and parity checker
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] ADDR_W = 8'h2e;
  localparam logic [7:0] ADDR_R = 8'h2f;
  logic clk, rst, i3c_mode, ccc_wr, ccc_pec_en, register_mod_field, ccc_par_dis, i2c_ccc_parity;
  logic ibi_en, ibi_done, lclk, sda_h, start_det, start_rep, bus_stop, sda_w, ack;
  logic sda_out, sda_oe_n, pec_enable, parity_enable, device_status_ibi, ibi_request;
  logic par_err_set, crc_fault_flag_set, packet_execute, packet_discard;
  logic [1:0] misc_err_clear, misc_error_status;
  logic [3:0] pending_int, seen;
  logic seen_clr;
  logic [7:0] tx_pec;
  int fails, n_checks;
  assign sda_w = sda_h & (sda_oe_n | sda_out);
  i3c_pec_parity_checker uut (.clk(clk), .rst(rst), .lclk(lclk), .i3c_mode(i3c_mode), .ccc_wr(ccc_wr),
    .ccc_pec_en(ccc_pec_en), .register_mod_field(register_mod_field), .ccc_par_dis(ccc_par_dis),
    .i2c_ccc_parity(i2c_ccc_parity), .low_id_code(4'h2), .high_id_code(3'h7), .ibi_en(ibi_en),
    .misc_err_clear(misc_err_clear), .ibi_done(ibi_done), .start_det(start_det), .start_rep(start_rep),
    .sda_in(sda_w), .bus_stop(bus_stop), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .tx_pec(tx_pec),
    .pec_enable(pec_enable), .parity_enable(parity_enable), .misc_error_status(misc_error_status),
    .device_status_ibi(device_status_ibi), .pending_int(pending_int), .par_err_set(par_err_set),
    .crc_fault_flag_set(crc_fault_flag_set), .packet_execute(packet_execute), .packet_discard(packet_discard),
    .ibi_request(ibi_request));
  host_model h (.lclk(lclk), .sda_h(sda_h), .start_det(start_det), .start_rep(start_rep),
    .bus_stop(bus_stop), .sda_w(sda_w));
  // one-cycle pulses are collected so a scenario can judge them after stop
  always @(posedge clk) seen <= seen_clr ? 4'h0 : (seen | {par_err_set, crc_fault_flag_set, packet_execute, packet_discard});
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic final_report;
    if (fails == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  task automatic stp;
    h.stop();
    repeat (8) @(negedge clk);
  endtask : stp
  task automatic ccc(input logic pe, input logic md, input logic pd);
    @(negedge clk);
    {ccc_pec_en, register_mod_field, ccc_par_dis} = {pe, md, pd};
    ccc_wr = 1'h1;
    @(negedge clk);
    ccc_wr = 1'h0;
    repeat (2) @(negedge clk);
  endtask : ccc
  task automatic clr(input logic [1:0] m, input logic ib);
    @(negedge clk);
    misc_err_clear = m;
    ibi_done = ib;
    @(negedge clk);
    misc_err_clear = 2'h0;
    ibi_done = 0;
    repeat (2) @(negedge clk);
  endtask : clr
  task automatic wr_pkt(input logic [7:0] d, input logic badt, input logic pec, input logic badpec);
    @(negedge clk);
    seen_clr = 1'h1;
    @(negedge clk);
    seen_clr = 1'h0;
    h.frame(1'h0, ADDR_W, ack);
    chk("addr ack", 8'h01, {7'h00, ack});
    h.send_byte(8'h31, 1'h0);
    h.send_byte(d, badt);
    if (pec) h.send_pec(badpec);
    stp();
  endtask : wr_pkt
  ////////////////////////////////////////////////////////////////////////
  task automatic t_parity;
    chk("pec default", 8'h00, {7'h00, pec_enable});
    chk("parity default", 8'h01, {7'h00, parity_enable});
    wr_pkt(8'h00, 1'h0, 1'h0, 1'h0);
    chk("good write", 8'h02, {4'h0, seen});
    wr_pkt(8'h00, 1'h1, 1'h0, 1'h0);
    chk("bad t write", 8'h09, {4'h0, seen});
    chk("misc", 8'h01, {6'h00, misc_error_status});
    chk("ibi flag", 8'h01, {7'h00, device_status_ibi});
    chk("pending", 8'h01, {4'h0, pending_int});
    chk("ibi req", 8'h01, {7'h00, ibi_request});
    clr(2'h0, 1'h1);
    chk("misc held", 8'h01, {6'h00, misc_error_status});
    chk("pending done", 8'h00, {4'h0, pending_int});
    clr(2'h1, 1'h0);
    chk("misc cleared", 8'h00, {6'h00, misc_error_status});
  endtask : t_parity
  task automatic t_read;
    // broadcast header is acked and never enters the crc
    h.frame(1'h0, 8'hfc, ack);
    chk("bcast ack", 8'h01, {7'h00, ack});
    stp();
    chk("bcast crc", 8'h00, tx_pec);
    h.frame(1'h0, ADDR_W, ack);
    h.send_byte(8'h31, 1'h1);
    for (int i = 0; i < 2; i++) begin
      h.frame(1'h1, ADDR_R, ack);
      chk("sr nack", 8'h00, {7'h00, ack});
    end
    stp();
    chk("read misc", 8'h01, {6'h00, misc_error_status});
    clr(2'h1, 1'h1);
    h.frame(1'h0, ADDR_W, ack);
    h.send_byte(8'h31, 1'h0);
    h.frame(1'h1, ADDR_R, ack);
    chk("sr ack", 8'h01, {7'h00, ack});
    chk("tx pec seed", h.crc8(8'h00, ADDR_R), tx_pec);
    stp();
  endtask : t_read
  task automatic t_pec;
    ccc(1'h1, 1'h1, 1'h0);
    chk("pec on", 8'h01, {7'h00, pec_enable});
    wr_pkt(8'h5a, 1'h0, 1'h1, 1'h0);
    chk("pec good", 8'h02, {4'h0, seen});
    wr_pkt(8'h5a, 1'h0, 1'h1, 1'h1);
    chk("pec bad", 8'h05, {4'h0, seen});
    chk("pec misc", 8'h02, {6'h00, misc_error_status});
    chk("pec pending", 8'h01, {4'h0, pending_int});
    clr(2'h2, 1'h1);
    wr_pkt(8'h5b, 1'h0, 1'h1, 1'h0);
    chk("pec reseed", 8'h02, {4'h0, seen});
    // parity may only be turned off while the mod field is zero
    ccc(1'h1, 1'h1, 1'h1);
    chk("parity kept", 8'h01, {7'h00, parity_enable});
    ccc(1'h1, 1'h0, 1'h1);
    chk("parity off", 8'h00, {7'h00, parity_enable});
    wr_pkt(8'h5c, 1'h1, 1'h1, 1'h0);
    chk("t ignored", 8'h02, {4'h0, seen});
  endtask : t_pec
  initial begin
    {ccc_wr, ccc_pec_en, register_mod_field, ccc_par_dis, i2c_ccc_parity, ibi_en, ibi_done, i3c_mode} = '0;
    misc_err_clear = 2'h0;
    seen_clr = 1'h1;
    fails = 0;
    n_checks = 0;
    rst = 1'h1;
    repeat (4) @(negedge clk);
    rst = 1'h0;
    repeat (2) @(negedge clk);
    i3c_mode = 1'h1;
    ibi_en = 1'h1;
    repeat (3) @(negedge clk);
    t_parity();
    t_read();
    t_pec();
    i3c_mode = 1'h0;
    repeat (3) @(negedge clk);
    chk("i2c parity", 8'h00, {7'h00, parity_enable});
    final_report();
  end
  // hang guard
  initial begin
    #2ms;
    fails++;
    final_report();
  end
endmodule : tb

// ===== verilog/i3c_pec_parity_checker.sv
// crc-8 packet error code and t-bit parity checker for an i3c basic target
//
// Operation
// - pec and parity only in i3c basic; i2c has parity on ccc only
// - with pec enabled an 8-bit code ends each transaction
// - crc covers message bytes only, not conditions, t/ack bits, 7e header
// - crc-8 with generator x^8 + x^2 + x + 1
// - crc register starts at zero for each code calculation
// - i3c entry: parity on, pec off; parity off only with mod field zero
// - parity disabled means host t bits are ignored
// - t bit is odd parity: 0 for odd ones count, 1 for even
// - only parity error classes te1 and te2 are detected
// - write parity error drops byte and rest until stop
// - parity error sets misc bit 0, ibi pending, pending code 0001
// - read data carries no parity; device t bit continues or ends
// - errored write part makes every repeated start read nack
// - pec mismatch on write: no execute, set misc bit 1 and ibi
// - parity error with pec on discards packet and sets parity flags
// - read: check received code, fresh code from repeated start address
// - transmitted code covers the last acked read address, after a start or a repeated start, and the read data bytes after it
// - ccc packets get the same error handling as read and write
// - errors held in status; ibi request raised when enabled
`timescale 1ns/1ps
module i3c_pec_parity_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic lclk,
  input wire logic i3c_mode,
  input wire logic ccc_wr,
  input wire logic ccc_pec_en,
  input wire logic register_mod_field,
  input wire logic ccc_par_dis,
  input wire logic i2c_ccc_parity,
  input wire logic [3:0] low_id_code,
  input wire logic [2:0] high_id_code,
  input wire logic ibi_en,
  input wire logic [1:0] misc_err_clear,
  input wire logic ibi_done,
  input wire logic start_det,
  input wire logic start_rep,
  input wire logic sda_in,
  input wire logic bus_stop,
  output logic sda_out,
  output logic sda_oe_n,
  output logic [7:0] tx_pec,
  output logic pec_enable,
  output logic parity_enable,
  output logic [1:0] misc_error_status,
  output logic device_status_ibi,
  output logic [3:0] pending_int,
  output logic par_err_set,
  output logic crc_fault_flag_set,
  output logic packet_execute,
  output logic packet_discard,
  output logic ibi_request
);

  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = {r[6:0], 1'b0} ^ ((r[7] ^ b[i]) ? pec_pkg::CRC_POLY : 8'h00);
    end
    return r;
  endfunction : crc8

  //////////////////////////////////////////////////////////////////////
  // configuration, core clock

  logic i3c_q, pec_en_q, par_dis_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      i3c_q <= 1'b0;
      pec_en_q <= pec_pkg::PEC_EN_RST;
      par_dis_q <= pec_pkg::PAR_DIS_RST;
    end else begin
      i3c_q <= i3c_mode;
      if (!i3c_mode || !i3c_q) begin
        pec_en_q <= pec_pkg::PEC_EN_RST;
        par_dis_q <= pec_pkg::PAR_DIS_RST;
      end else if (ccc_wr) begin
        pec_en_q <= ccc_pec_en;
        if (!register_mod_field) begin
          par_dis_q <= ccc_par_dis;
        end
      end
    end
  end

  logic par_act, pec_act;
  assign par_act = i3c_mode ? !par_dis_q : i2c_ccc_parity;
  assign pec_act = pec_en_q & i3c_mode;
  assign pec_enable = pec_en_q;
  assign parity_enable = par_act;

  //////////////////////////////////////////////////////////////////////
  // link clock side
  // settings are quasi-static, so a plain two-stage sync per bit is enough

  logic [8:0] cfg_s1, cfg_s2;
  always_ff @(posedge lclk or posedge rst) begin
    if (rst) begin
      cfg_s1 <= 9'h000;
      cfg_s2 <= 9'h000;
    end else begin
      cfg_s1 <= {par_act, pec_act, low_id_code, high_id_code};
      cfg_s2 <= cfg_s1;
    end
  end

  logic par_s, pec_s;
  logic [6:0] id_s;
  assign par_s = cfg_s2[8];
  assign pec_s = cfg_s2[7];
  assign id_s = cfg_s2[6:0];

  logic [3:0] bit_q;
  logic [7:0] sh_q, crc_q;
  pec_pkg::phase_t ph_q;
  logic err_q, data_q, match_q, ack_q, par_tg_q, pec_tg_q;

  logic [7:0] byte_c;
  logic adr_hit, bcast_w, pec_fail, rd_refuse, addr_end, tbit_bad;
  assign byte_c = {sh_q[6:0], sda_in};
  assign adr_hit = byte_c[7:1] == id_s;
  assign bcast_w = byte_c[7:1] == pec_pkg::BCAST_ADDR && !byte_c[0];
  assign pec_fail = pec_s & data_q & !match_q;
  assign rd_refuse = err_q | pec_fail;
  assign addr_end = ph_q == pec_pkg::ph_addr && bit_q == pec_pkg::BIT_LAST && !start_det;
  assign tbit_bad = par_s && sda_in != ~^sh_q;

  always_ff @(posedge lclk or posedge rst) begin
    if (rst) begin
      bit_q <= 4'h0;
      sh_q <= 8'h00;
    end else if (start_det) begin
      bit_q <= 4'h0;
    end else begin
      bit_q <= (bit_q == pec_pkg::BIT_T) ? 4'h0 : bit_q + 4'h1;
      if (bit_q != pec_pkg::BIT_T) begin
        sh_q <= byte_c; // t and ack bits never enter the byte
      end
    end
  end

  always_ff @(posedge lclk or posedge rst) begin
    if (rst) begin
      ph_q <= pec_pkg::ph_idle;
      err_q <= 1'b0;
      data_q <= 1'b0;
      match_q <= 1'b0;
      crc_q <= pec_pkg::CRC_SEED;
      par_tg_q <= 1'b0;
      pec_tg_q <= 1'b0;
    end else if (start_det) begin
      ph_q <= pec_pkg::ph_addr;
      if (!start_rep) begin
        err_q <= 1'b0;
        data_q <= 1'b0;
        match_q <= 1'b0;
        crc_q <= pec_pkg::CRC_SEED;
      end
    end else begin
      case (ph_q)
        pec_pkg::ph_addr: begin
          if (bit_q == pec_pkg::BIT_LAST) begin
            if (bcast_w) begin
              ph_q <= pec_pkg::ph_wdata;
              crc_q <= pec_pkg::CRC_SEED;
            end else if (adr_hit && !byte_c[0]) begin
              ph_q <= pec_pkg::ph_wdata;
              data_q <= 1'b0;
              crc_q <= crc8(pec_pkg::CRC_SEED, byte_c);
            end else if (adr_hit && rd_refuse) begin
              ph_q <= pec_pkg::ph_idle;
              err_q <= 1'b1;
              if (pec_fail && !err_q) begin
                pec_tg_q <= ~pec_tg_q;
              end
            end else if (adr_hit) begin
              ph_q <= pec_pkg::ph_rdata;
              crc_q <= crc8(pec_pkg::CRC_SEED, byte_c);
            end else begin
              ph_q <= pec_pkg::ph_idle;
            end
          end
        end
        pec_pkg::ph_wdata: begin
          if (bit_q == pec_pkg::BIT_T && ack_q) begin
            // ninth bit after the address is our ack: no parity, keeps address out of the crc twice
            ph_q <= pec_pkg::ph_wdata;
          end else if (bit_q == pec_pkg::BIT_T) begin
            if (tbit_bad) begin
              err_q <= 1'b1;
              par_tg_q <= ~par_tg_q;
              ph_q <= pec_pkg::ph_idle;
            end else begin
              match_q <= crc_q == sh_q;
              crc_q <= crc8(crc_q, sh_q);
              data_q <= 1'b1;
            end
          end
        end
        pec_pkg::ph_rdata: begin
          if (bit_q == pec_pkg::BIT_LAST) begin
            crc_q <= crc8(crc_q, byte_c);
          end
        end
        pec_pkg::ph_idle: begin
          ph_q <= pec_pkg::ph_idle;
        end
        default: begin
          ph_q <= pec_pkg::ph_idle;
        end
      endcase
    end
  end

  always_ff @(posedge lclk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= addr_end && (bcast_w || (adr_hit && (!byte_c[0] || !rd_refuse)));
    end
  end

  // drive on the falling edge so sda never moves while scl is high
  logic oe_n_q;
  always_ff @(negedge lclk or posedge rst) begin
    if (rst) begin
      oe_n_q <= 1'b1;
    end else begin
      oe_n_q <= !ack_q;
    end
  end

  assign sda_oe_n = oe_n_q;
  assign sda_out = 1'b0;
  assign tx_pec = crc_q;

  //////////////////////////////////////////////////////////////////////
  // back into the core clock
  // link clock stops after stop, so link state is frozen when sampled

  logic [2:0] par_sy, pec_sy, stop_sy;
  logic [3:0] st_s1, st_s2;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      par_sy <= 3'h0;
      pec_sy <= 3'h0;
      stop_sy <= 3'h0;
      st_s1 <= 4'h0;
      st_s2 <= 4'h0;
    end else begin
      par_sy <= {par_sy[1:0], par_tg_q};
      pec_sy <= {pec_sy[1:0], pec_tg_q};
      stop_sy <= {stop_sy[1:0], bus_stop};
      st_s1 <= {ph_q == pec_pkg::ph_wdata, data_q, match_q, err_q};
      st_s2 <= st_s1;
    end
  end

  logic par_evt, pec_evt, stop_rise, wr_end, wr_bad_pec, pec_set, err_any;
  assign par_evt = par_sy[2] ^ par_sy[1];
  assign pec_evt = pec_sy[2] ^ pec_sy[1];
  assign stop_rise = stop_sy[1] & !stop_sy[2];
  assign wr_end = stop_rise & st_s2[2] & st_s2[3];
  assign wr_bad_pec = wr_end & !st_s2[0] & pec_act & !st_s2[1];
  assign pec_set = pec_evt | wr_bad_pec;
  assign err_any = par_evt | pec_set;

  logic par_set_q, pec_set_q, exec_q, disc_q, ibi_q;
  logic [1:0] misc_q;
  logic [3:0] pend_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      par_set_q <= 1'b0;
      pec_set_q <= 1'b0;
      exec_q <= 1'b0;
      disc_q <= 1'b0;
    end else begin
      par_set_q <= par_evt;
      pec_set_q <= pec_set;
      exec_q <= wr_end & !st_s2[0] & !wr_bad_pec;
      // an error on the first data byte must still discard
      disc_q <= stop_rise & (st_s2[0] | wr_bad_pec);
    end
  end

  // set beats a clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      misc_q <= 2'h0;
      ibi_q <= 1'b0;
      pend_q <= pec_pkg::PEND_NONE;
    end else begin
      misc_q[pec_pkg::MISC_PAR] <= par_evt | (misc_q[pec_pkg::MISC_PAR] & !misc_err_clear[0]);
      misc_q[pec_pkg::MISC_PEC] <= pec_set | (misc_q[pec_pkg::MISC_PEC] & !misc_err_clear[1]);
      ibi_q <= err_any | (ibi_q & !ibi_done);
      if (err_any) begin
        pend_q <= pec_pkg::PEND_CODE;
      end else if (ibi_done) begin
        pend_q <= pec_pkg::PEND_NONE;
      end
    end
  end

  assign par_err_set = par_set_q;
  assign crc_fault_flag_set = pec_set_q;
  assign packet_execute = exec_q;
  assign packet_discard = disc_q;
  assign misc_error_status = misc_q;
  assign device_status_ibi = ibi_q;
  assign pending_int = pend_q;
  assign ibi_request = ibi_q & ibi_en & i3c_mode;

  //////////////////////////////////////////////////////////////////////
  // checks

  sequence seq_rd_hit;
    addr_end && adr_hit && byte_c[0];
  endsequence

  sequence seq_tbit;
    ph_q == pec_pkg::ph_wdata && bit_q == pec_pkg::BIT_T && !start_det && !ack_q;
  endsequence

  AST_REFUSE_NACK: assert property (@(posedge lclk) disable iff (rst)
    seq_rd_hit and rd_refuse |=> !ack_q && err_q && ph_q == pec_pkg::ph_idle)
    else $error("errored read was not refused");

  AST_READ_ACK: assert property (@(posedge lclk) disable iff (rst)
    seq_rd_hit and !rd_refuse |=> ack_q && crc_q == crc8(pec_pkg::CRC_SEED, $past(byte_c)))
    else $error("read ack or fresh code seed wrong");

  AST_PARITY_ERR: assert property (@(posedge lclk) disable iff (rst)
    seq_tbit and (par_s && sda_in == ^sh_q) |=> err_q && ph_q == pec_pkg::ph_idle && par_tg_q != $past(par_tg_q))
    else $error("bad t bit not caught");

  AST_PARITY_OFF: assert property (@(posedge lclk) disable iff (rst)
    seq_tbit and !par_s |=> $stable(par_tg_q) && !err_q == !$past(err_q))
    else $error("t bit used while parity off");

  AST_BCAST_EXCL: assert property (@(posedge lclk) disable iff (rst)
    addr_end && bcast_w |=> crc_q == pec_pkg::CRC_SEED ##1 crc_q == pec_pkg::CRC_SEED)
    else $error("broadcast header entered crc");

  AST_ERR_HOLD: assert property (@(posedge lclk) disable iff (rst)
    err_q && !(start_det && !start_rep) |=> err_q)
    else $error("error dropped before new start");

  AST_ACK_ONE: assert property (@(posedge lclk) disable iff (rst)
    ack_q |=> !ack_q)
    else $error("ack held longer than one bit");

  AST_ACK_NOT_T: assert property (@(posedge lclk) disable iff (rst)
    ack_q && ph_q == pec_pkg::ph_wdata |=> (start_det && !start_rep) || ($stable(crc_q) && $stable(par_tg_q)))
    else $error("address ack bit taken as a t bit");

  AST_PAR_FLAGS: assert property (@(posedge clk) disable iff (rst)
    par_evt |=> par_err_set && misc_error_status[0] && device_status_ibi && pending_int == 4'h1)
    else $error("parity flags not set");

  AST_PEC_FLAGS: assert property (@(posedge clk) disable iff (rst)
    wr_bad_pec |=> crc_fault_flag_set && !packet_execute && packet_discard && misc_error_status[1])
    else $error("code mismatch not handled");

  AST_DEFAULTS: assert property (@(posedge clk) disable iff (rst)
    !i3c_mode ##1 i3c_mode |=> !pec_enable && parity_enable)
    else $error("i3c entry defaults wrong");

endmodule : i3c_pec_parity_checker

// ===== verilog/pec_pkg.sv
// constants for the packet error code and parity checker
package pec_pkg;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_SEED = 8'h00;
  localparam logic [6:0] BCAST_ADDR = 7'h7e;
  localparam logic [3:0] PEND_CODE = 4'h1;
  localparam logic [3:0] PEND_NONE = 4'h0;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_T = 4'h8;
  localparam int MISC_PAR = 0;
  localparam int MISC_PEC = 1;
  localparam logic PEC_EN_RST = 1'b0;
  localparam logic PAR_DIS_RST = 1'b0;
  typedef enum logic [1:0] {ph_addr, ph_wdata, ph_rdata, ph_idle} phase_t;
endpackage : pec_pkg
